// >>> rtl/srx_return_exec.sv
// Purpose: Decodes and executes the plain return and the literal return.
// Assumes: The fetch stage holds instr_word and instr_valid for a whole cycle.
// Notes:   Write-back outputs are one-phase pulses in the fourth phase of the first cycle; flush_q is high for the whole second cycle.
//
// How it works
// - Literal return opcode writes its 8-bit immediate into the accumulator.
// - Literal return pops the stack and loads the popped address into PC.
// - Literal return is one word, two cycles; write and pop in phase four.
// - Plain return opcode pops the stack into PC, accumulator left unchanged.
// - Plain return is one word, two cycles; pop happens in phase four.
// - After a PC change the second cycle is a no-operation, fetch discarded.
// - Each instruction cycle is four clock periods: decode, read, operate, write.
`timescale 1ns/1ps
module srx_return_exec
	import srx_pkg::*;
#(
	parameter int IW  = SRX_IW,
	parameter int PCW = SRX_PCW
)
(
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst_b,
	// From the fetch stage.
	input  wire logic           instr_valid,
	input  wire logic [IW-1:0]  instr_word,
	// From the return stack.
	input  wire logic [PCW-1:0] stack_top_entry,
	// To the accumulator.
	output logic                acc_we_q,
	output logic [SRX_DW-1:0]   acc_data_q,
	// To the stack and program counter.
	output logic                stack_pop_q,
	output logic                pc_load_q,
	output logic [PCW-1:0]      pc_data_q,
	// To fetch and status.
	output logic                flush_q,
	output logic                status_we_q,
	output logic [1:0]          phase_q
);

	// Refuse widths that the decode and the address path cannot serve.
	if (IW != SRX_IW || PCW < 1 || PCW > 16) begin : g_bad_width
		$error("srx_return_exec: unsupported word or address width");
	end

	srx_phase_if ph ();

	srx_phase_gen u_phase (
		.clk   (clk),
		.rst_b (rst_b),
		.ph    (ph)
	);

	srx_exec_t         ex_q;
	srx_exec_t         ex_d;
	logic [IW-1:0]     ir_q;
	logic [SRX_DW-1:0] lit_q;
	logic              is_lit;
	logic              is_ret;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign is_lit = (instr_word[IW-1:SRX_OPC_LSB] == SRX_LIT_OPC);
	assign is_ret = (instr_word == SRX_RET_WORD);

	// The second cycle ignores the word already fetched.
	always_comb begin
		ex_d = ex_q;
		case (ex_q)
			SRX_EX_IDLE: begin
				if (ph.phase == SRX_Q1 && instr_valid) begin
					if (is_lit) begin
						ex_d = SRX_EX_LIT;
					end else if (is_ret) begin
						ex_d = SRX_EX_RET;
					end
				end
			end
			SRX_EX_LIT, SRX_EX_RET: begin
				if (ph.cycle_end) begin
					ex_d = SRX_EX_NOP;
				end
			end
			SRX_EX_NOP: begin
				if (ph.cycle_end) begin
					ex_d = SRX_EX_IDLE;
				end
			end
			default: ex_d = SRX_EX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ex_q <= SRX_EX_IDLE;
		end else begin
			ex_q <= ex_d;
		end
	end

	// ----------------------------------------
	// Instruction and literal capture
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ir_q <= SRX_IR_RST;
		end else if (ex_q == SRX_EX_IDLE && ph.phase == SRX_Q1 && instr_valid) begin
			ir_q <= instr_word;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lit_q <= SRX_ACC_RST;
		end else if (ex_q == SRX_EX_LIT && ph.phase == SRX_Q2) begin
			lit_q <= ir_q[SRX_LIT_LSB +: SRX_DW];
		end
	end

	// ----------------------------------------
	// Write-back pulses, high during the fourth phase
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			acc_we_q   <= 1'b0;
			acc_data_q <= SRX_ACC_RST;
		end else begin
			acc_we_q <= (ex_q == SRX_EX_LIT && ph.phase == SRX_Q3);
			if (ex_q == SRX_EX_LIT && ph.phase == SRX_Q3) begin
				acc_data_q <= lit_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stack_pop_q <= 1'b0;
			pc_load_q   <= 1'b0;
			pc_data_q   <= PCW'(SRX_PC_RST);
		end else begin
			stack_pop_q <= (ex_q == SRX_EX_LIT || ex_q == SRX_EX_RET)
				&& ph.phase == SRX_Q3;
			pc_load_q   <= (ex_q == SRX_EX_LIT || ex_q == SRX_EX_RET)
				&& ph.phase == SRX_Q3;
			if ((ex_q == SRX_EX_LIT || ex_q == SRX_EX_RET) && ph.phase == SRX_Q3) begin
				pc_data_q <= stack_top_entry;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			flush_q <= 1'b0;
		end else begin
			flush_q <= (ex_d == SRX_EX_NOP);
		end
	end

	// Status flags are never written by either return.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status_we_q <= 1'b0;
		end else begin
			status_we_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_q <= 2'(SRX_Q1);
		end else begin
			phase_q <= 2'(ph.phase);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_lit_acc;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_LIT && ph.phase == SRX_Q3) |=>
			acc_we_q && acc_data_q == $past(ir_q[SRX_DW-1:0]);
	endproperty
	a_lit_acc: assert property (p_lit_acc) else $error("literal not written");

	property p_lit_pop;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_LIT && ph.phase == SRX_Q3) |=>
			stack_pop_q && pc_load_q && pc_data_q == $past(stack_top_entry);
	endproperty
	a_lit_pop: assert property (p_lit_pop) else $error("literal return no pop");

	property p_lit_cycles;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_LIT && ph.phase == SRX_Q4) |=>
			(ex_q == SRX_EX_NOP)[*4] ##1 (ex_q == SRX_EX_IDLE);
	endproperty
	a_lit_cycles: assert property (p_lit_cycles) else $error("literal cycles");

	property p_ret_pop;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_RET && ph.phase == SRX_Q3) |=>
			pc_load_q && stack_pop_q && !acc_we_q && pc_data_q == $past(stack_top_entry);
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("return pop wrong");

	property p_ret_cycles;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_RET && ph.phase == SRX_Q4) |->
			stack_pop_q ##1 (ex_q == SRX_EX_NOP && !stack_pop_q)[*4];
	endproperty
	a_ret_cycles: assert property (p_ret_cycles) else $error("return timing");

	property p_nop;
		@(posedge clk) disable iff (!rst_b)
		(ex_q == SRX_EX_NOP) |-> flush_q && !acc_we_q && !stack_pop_q && !pc_load_q;
	endproperty
	a_nop: assert property (p_nop) else $error("second cycle not idle");

	property p_phase;
		@(posedge clk) disable iff (!rst_b)
		(ph.phase == SRX_Q1) |=> (ph.phase == SRX_Q2) ##1 (ph.phase == SRX_Q3)
			##1 (ph.phase == SRX_Q4) ##1 (ph.phase == SRX_Q1);
	endproperty
	a_phase: assert property (p_phase) else $error("phase order broken");

	property p_flags;
		@(posedge clk) disable iff (!rst_b)
		(ex_q != SRX_EX_IDLE) |-> !status_we_q;
	endproperty
	a_flags: assert property (p_flags) else $error("status written");

endmodule

// >>> rtl/srx_pkg.sv
// Purpose: Shared constants and types for the subroutine return executor.
// Assumes: One instruction cycle is four clock periods, one per phase.
// Notes:   Opcode patterns and field positions for both return instructions.
package srx_pkg;

	localparam int          SRX_IW        = 14;
	localparam int          SRX_PCW       = 13;
	localparam int          SRX_DW        = 8;
	localparam int          SRX_PHASES    = 4;
	localparam int          SRX_LIT_LSB   = 0;
	localparam int          SRX_OPC_LSB   = 10;
	localparam logic [3:0]  SRX_LIT_OPC   = 4'hD;
	localparam logic [13:0] SRX_RET_WORD  = 14'h0_008;
	localparam logic [7:0]  SRX_ACC_RST   = 8'h00;
	localparam logic [12:0] SRX_PC_RST    = 13'h0_000;
	localparam logic [13:0] SRX_IR_RST    = 14'h0_000;

	typedef enum logic [1:0] {
		SRX_Q1,
		SRX_Q2,
		SRX_Q3,
		SRX_Q4
	} srx_phase_t;

	typedef enum logic [1:0] {
		SRX_EX_IDLE,
		SRX_EX_LIT,
		SRX_EX_RET,
		SRX_EX_NOP
	} srx_exec_t;

endpackage

// >>> rtl/srx_phase_if.sv
// Purpose: Carries the instruction cycle phase from the sequencer to the executor.
// Assumes: Both ends run on the same clock.
// Notes:   Phase changes once every clock.
`timescale 1ns/1ps
interface srx_phase_if
	import srx_pkg::*;
	();
	srx_phase_t phase;
	logic       cycle_end;

	modport gen (output phase, output cycle_end);
	modport use_side (input phase, input cycle_end);
endinterface

// >>> rtl/srx_phase_gen.sv
// Purpose: Steps the four phases of each instruction cycle.
// Assumes: One phase per clock period.
// Notes:   Reset starts a fresh cycle at the first phase.
`timescale 1ns/1ps
module srx_phase_gen
	import srx_pkg::*;
(
	// Clock and reset.
	input  wire logic     clk,
	input  wire logic     rst_b,
	// Phase out.
	srx_phase_if.gen      ph
);

	srx_phase_t phase_q;

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			phase_q <= SRX_Q1;
		end else begin
			case (phase_q)
				SRX_Q1:  phase_q <= SRX_Q2;
				SRX_Q2:  phase_q <= SRX_Q3;
				SRX_Q3:  phase_q <= SRX_Q4;
				SRX_Q4:  phase_q <= SRX_Q1;
				default: phase_q <= SRX_Q1;
			endcase
		end
	end

	assign ph.phase     = phase_q;
	assign ph.cycle_end = (phase_q == SRX_Q4);

endmodule

// >>> dv/srx_stack_model.sv
// Purpose: Return stack partner of the return executor.
// Assumes: Bench pushes one address ahead of each return it sends.
// Notes:   An empty stack shows the inverse of the last popped entry.
`timescale 1ns/1ps
module srx_stack_model
	import srx_pkg::*;
(
	// Clock.
	input  wire logic               clk,
	// Bench side.
	input  wire logic               push,
	input  wire logic [SRX_PCW-1:0] push_val,
	// Executor side.
	input  wire logic               stack_pop_q,
	output logic [SRX_PCW-1:0]      stack_top_entry
);
	logic [SRX_PCW-1:0] mem_q [8];
	logic [2:0]         sp_q   = 3'h0;
	logic [SRX_PCW-1:0] gone_q = 13'h0_000;

	always @(posedge clk) begin
		if (push) begin
			mem_q[sp_q] <= push_val;
			sp_q        <= sp_q + 3'h1;
		end else if (stack_pop_q && sp_q != 3'h0) begin
			gone_q <= ~mem_q[sp_q - 3'h1];
			sp_q   <= sp_q - 3'h1;
		end
	end

	assign stack_top_entry = (sp_q != 3'h0) ? mem_q[sp_q - 3'h1] : gone_q;
endmodule

// >>> dv/subroutine_return_exec_tb.sv
// Purpose: Self-checking bench for the return executor.
// Assumes: Each word is held for eight clocks, the length of one return.
// Notes:   Expected results queue up in the driver and a monitor retires them.
`timescale 1ns/1ps
module subroutine_return_exec_tb;
	import srx_pkg::*;
	typedef struct packed {logic we; logic [7:0] acc; logic [12:0] pc;} srx_note_t;
	logic        clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, push = 1'b0;
	logic [13:0] instr_word = 14'h0_000;
	logic [12:0] push_val = 13'h0_000, top;
	logic        acc_we_q, stack_pop_q, pc_load_q, flush_q, status_we_q;
	logic [7:0]  acc_data_q, acc_exp = SRX_ACC_RST;
	logic [12:0] pc_data_q;
	logic [1:0]  phase_q, ph_prev;
	int          n_mismatch = 0, n_tests = 0, seed = 32'h7aee, cyc = 0, last = -1;
	srx_note_t   notes[$], nt;

	initial forever #4 clk = ~clk;

	srx_stack_model srx_stack_model_i (.clk(clk), .push(push), .push_val(push_val),
		.stack_pop_q(stack_pop_q), .stack_top_entry(top));
	srx_return_exec srx_return_exec_i (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_word(instr_word), .stack_top_entry(top), .acc_we_q(acc_we_q),
		.acc_data_q(acc_data_q), .stack_pop_q(stack_pop_q), .pc_load_q(pc_load_q),
		.pc_data_q(pc_data_q), .flush_q(flush_q), .status_we_q(status_we_q),
		.phase_q(phase_q));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic send(input logic v, input logic [13:0] w);
		logic        go;
		logic [12:0] a;
		a  = 13'($random(seed));
		go = v && (w[13:10] === SRX_LIT_OPC || w === SRX_RET_WORD);
		if (go && w[13:10] === SRX_LIT_OPC)
			acc_exp = w[7:0];
		if (go)
			notes.push_back({w[13:10] === SRX_LIT_OPC, acc_exp, a});
		instr_valid = v;
		instr_word  = w;
		push        = go;
		push_val    = a;
		@(posedge clk);
		#1;
		push = 1'b0;
		repeat (7) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Monitor: retires one note per program counter load.
	// --------------------------------------------------------------
	always @(posedge clk) begin
		#2;
		cyc++;
		if (rst_b) begin
			chk("status_we", 16'h0_000, 16'(status_we_q));
			chk("pop_with_load", 16'(pc_load_q), 16'(stack_pop_q));
			if (cyc > 9)
				chk("phase", 16'(2'(ph_prev + 2'h1)), 16'(phase_q));
			if (pc_load_q !== 1'b1)
				chk("acc_we_alone", 16'h0_000, 16'(acc_we_q));
			if (last >= 0 && cyc - last inside {[1:4]})
				chk("flush", 16'h0_001, 16'(flush_q));
			if (last >= 0 && cyc - last == 5)
				chk("flush_end", 16'h0_000, 16'(flush_q));
			if (pc_load_q === 1'b1) begin
				if (notes.size() == 0) begin
					chk("spurious_load", 16'h0_000, 16'h0_001);
				end else begin
					nt = notes.pop_front();
					chk("pc_data", 16'(nt.pc), 16'(pc_data_q));
					chk("acc_we", 16'(nt.we), 16'(acc_we_q));
					chk("acc_data", 16'(nt.acc), 16'(acc_data_q));
					if (last >= 0)
						chk("spacing", 16'h0_000, 16'((cyc - last) % 8));
				end
				last = cyc;
			end
		end
		ph_prev = phase_q;
	end

	initial begin
		#40000;
		n_mismatch++;
		stop_test();
	end

	initial begin
		logic [31:0] r;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		send(1'b1, SRX_RET_WORD);
		send(1'b1, 14'h3_4A5);
		send(1'b1, SRX_RET_WORD);
		send(1'b0, 14'h3_7FF);
		send(1'b1, 14'h0_009);
		send(1'b1, 14'h3_0FF);
		for (int i = 0; i < 30; i++) begin
			r = $random(seed);
			case (r[1:0])
				2'h0: send(1'b1, SRX_RET_WORD);
				2'h1: send(1'b1, {SRX_LIT_OPC, r[11:2]});
				default: send(r[2], r[15:2]);
			endcase
		end
		send(1'b0, 14'h0_000);
		chk("pending", 16'h0_000, 16'(notes.size()));
		stop_test();
	end
endmodule
